// >>> sim/dcs_host_rx.sv
// Host-side serial receiver for the shifted conversion result
`timescale 1ns/100ps
module dcs_host_rx (
  input wire logic mclk, // System clock
  input wire logic ser_clk, // Shift clock from the block
  input wire logic ser_out, // Serial data from the block
  output logic [11:0] rx_word // Last twelve bits received
);
  logic clk_r;
  logic bit_r;
  // Keep the bit from before the fall, since data moves as the clock drops
  always_ff @(posedge mclk) begin
    clk_r <= ser_clk;
    bit_r <= ser_out;
    if (clk_r && !ser_clk) begin
      rx_word <= {rx_word[10:0], bit_r};
    end
  end
endmodule : dcs_host_rx

// >>> sim/testbench.sv
// Pin-level bench for the channel sequencer
`timescale 1ns/100ps
module testbench;
  import dcs_pkg::*;
  logic mclk, rstn, strobe, load_en, clear_en_n, count_en, trigger, mux_en;
  logic twos_comp, delay_out, eoc, ser_out, ser_clk;
  logic [3:0] addr_in, addr_out;
  logic [1:0] gain_in, gain_out;
  logic [2:0] grp_oe_n;
  logic [11:0] adc_code, data_o, data_oe, rx_word;
  logic [15:0] chan_sel;
  int n_fail = 0;
  int check_count = 0;
  // Short settle and bit periods keep the run brief
  dcs_sequencer #(.DELAY_CYC(20), .BIT_DIV(4)) i_dcs_sequencer (
    .mclk(mclk), .rstn(rstn), .strobe(strobe), .load_en(load_en),
    .clear_en_n(clear_en_n), .count_en(count_en), .trigger(trigger),
    .mux_en(mux_en), .addr_in(addr_in), .gain_in(gain_in),
    .twos_comp(twos_comp), .grp_oe_n(grp_oe_n), .adc_code(adc_code),
    .addr_out(addr_out), .chan_sel(chan_sel), .gain_out(gain_out),
    .delay_out(delay_out), .eoc(eoc), .data_o(data_o), .data_oe(data_oe),
    .ser_out(ser_out), .ser_clk(ser_clk));
  dcs_host_rx i_dcs_host_rx (.mclk(mclk), .ser_clk(ser_clk),
    .ser_out(ser_out), .rx_word(rx_word));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // Strobe held low long enough to pass the two-flop synchroniser
  task automatic strobe_fall;
    @(negedge mclk) strobe = 1'b0;
    repeat (6) @(negedge mclk);
    strobe = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : strobe_fall
  // Bounded waits for a whole conversion, then result checks
  task automatic convert(logic [11:0] exp);
    int n;
    n = 0;
    while (eoc !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("eoc", 16'(eoc), 16'h1);
    while (eoc !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
    chk("data_o", 16'(data_o), 16'(exp));
    chk("rx_word", 16'(rx_word), 16'(adc_code));
  endtask : convert
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    strobe = 1'b1;
    load_en = 1'b0;
    clear_en_n = 1'b1;
    count_en = 1'b1;
    trigger = 1'b0;
    mux_en = 1'b1;
    addr_in = 4'h5;
    gain_in = 2'h2;
    twos_comp = 1'b0;
    grp_oe_n = 3'h7;
    adc_code = 12'ha5c;
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    chk("addr_out", 16'(addr_out), 16'h0);
    chk("eoc", 16'(eoc), 16'h0);
    // Random load with trigger low: settle ends without a conversion
    strobe_fall();
    chk("addr_out", 16'(addr_out), 16'h5);
    chk("gain_out", 16'(gain_out), 16'h2);
    chk("chan_sel", chan_sel, 16'h0020);
    chk("delay_out", 16'(delay_out), 16'h1);
    repeat (30) @(negedge mclk);
    chk("eoc", 16'(eoc), 16'h0);
    trigger = 1'b1;
    convert(12'ha5c);
    // Two's complement flips only the parallel MSB
    twos_comp = 1'b1;
    adc_code = 12'h3c3;
    addr_in = 4'hf;
    strobe_fall();
    convert(12'hbc3);
    mux_en = 1'b0;
    repeat (4) @(negedge mclk);
    chk("chan_sel", chan_sel, 16'h0);
    mux_en = 1'b1;
    // Every enable pattern, low drives its nibble
    for (int i = 0; i < 8; i++) begin
      grp_oe_n = 3'(i);
      repeat (4) @(negedge mclk);
      chk("data_oe", 16'(data_oe), 16'({{4{~grp_oe_n[0]}},
        {4{~grp_oe_n[1]}}, {4{~grp_oe_n[2]}}}));
    end
    // Sequential steps from 15: wrap, step, hold, clear; all gain codes
    trigger = 1'b0;
    load_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      count_en = (k != 2);
      clear_en_n = (k != 3);
      gain_in = 2'(k);
      strobe_fall();
      chk("addr_out", 16'(addr_out), 16'(k == 1 || k == 2));
      chk("gain_out", 16'(gain_out), 16'(k));
    end
    wrap_up();
  end
endmodule : testbench

// >>> src/dcs_pkg.sv
// Shared constants for the channel sequencer
package dcs_pkg;
  localparam int DCS_CLK_MHZ = 50;
  localparam int DCS_DELAY_US = 20;
  localparam int DCS_DELAY_CYC = DCS_DELAY_US * DCS_CLK_MHZ;
  localparam int DCS_RES_BITS = 12;
  localparam int DCS_NIB_W = 4;
  localparam int DCS_ADDR_W = 4;
  localparam int DCS_GAIN_W = 2;
  localparam int DCS_CH_SE = 16;
  localparam int DCS_CH_DIFF = 8;
  localparam int DCS_BIT_DIV = 33;
  localparam logic [3:0] DCS_ADDR_RST = 4'h0;
  localparam logic [1:0] DCS_GAIN_RST = 2'h0;
  typedef enum logic [1:0] {DCS_IDLE, DCS_SETTLE, DCS_CONV} dcs_state_t;
endpackage : dcs_pkg

// >>> src/dcs_sequencer.sv
// Channel sequencer and converter control for the acquisition subsystem
//
// Function
// - Three nibble groups each driven only while its active-low enable is low.
// - Multiplexer connected only while mux enable input is high.
// - Result shifted out NRZ, MSB first; receiver samples on falling clock.
// - Address register sequences only while count enable is high.
// - Address register contents shown in binary on four outputs.
// - Random mode decodes address inputs as straight binary channel select.
// - 20 us delay pulse; its falling edge starts conversion.
// - Load enable high selects sequential, low random with strobe capture.
// - Strobe fall starts sequencing in sequential mode, conversion in random.
// - Clear enable low with strobe fall zeroes the address register.
// - Trigger rising edge resets converter and starts next conversion.
// - End-of-conversion high during conversion, low once result complete.
// - Gain code held in a register and shown on two outputs.
// - Parallel output MSB true for binary coding, complemented for two's complement; serial MSB always true.
// - Twelve-bit result; throughput of 33 kHz including switching.
// - Delay pulse end starts conversion only while trigger is high.
// - In sequential mode each strobe fall with count and clear enables high adds one to the address, wrapping to zero after the top channel.
`timescale 1ns/100ps
module dcs_sequencer
  import dcs_pkg::*;
#(
  parameter int DELAY_CYC = DCS_DELAY_CYC, // Settling pulse length
  parameter int BIT_DIV = DCS_BIT_DIV, // Cycles per serial bit
  parameter bit DIFF = 1'b0 // 1 = eight differential channels
) (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic rstn, // Synchronous reset, low
  input wire logic strobe, // Pin: acts on falling edge
  input wire logic load_en, // Pin: high sequential, low random
  input wire logic clear_en_n, // Pin: low clears address on strobe
  input wire logic count_en, // Pin: high allows sequencing
  input wire logic trigger, // Pin: rising edge starts conversion
  input wire logic mux_en, // Pin: high connects multiplexer
  input wire logic [3:0] addr_in, // Pin: random channel address
  input wire logic [1:0] gain_in, // Pin: gain select code
  input wire logic twos_comp, // Pin: high for two's complement
  input wire logic [2:0] grp_oe_n, // Pins: nibble enables, low drives
  input wire logic [11:0] adc_code, // Converter result, mclk domain
  output logic [3:0] addr_out, // Address register
  output logic [15:0] chan_sel, // One-hot channel switch
  output logic [1:0] gain_out, // Gain register
  output logic delay_out, // Settling pulse
  output logic eoc, // High while converting
  output logic [11:0] data_o, // Parallel result
  output logic [11:0] data_oe, // Per-bit output enable
  output logic ser_out, // Serial data
  output logic ser_clk // Shift clock
);
  localparam logic [3:0] TOP_CH = DIFF ? 4'(DCS_CH_DIFF - 1) :
                                         4'(DCS_CH_SE - 1);
  localparam int DW = $clog2(DELAY_CYC + 1);
  localparam int BW = $clog2(BIT_DIV + 1);

  logic [12:0] pins_s;
  logic [3:0] addr_s;
  logic [1:0] gain_s;
  logic strobe_q_r, trig_q_r;
  logic stb_fall, trg_rise;

  // All pins cross into mclk before use
  dcs_sync #(.W(13)) u_sync_ctl (
    .mclk(mclk), .rstn(rstn),
    .din({strobe, load_en, clear_en_n, count_en, trigger, mux_en,
          twos_comp, grp_oe_n, 3'h0}),
    .dout(pins_s)
  );
  dcs_sync #(.W(6)) u_sync_dat (
    .mclk(mclk), .rstn(rstn),
    .din({addr_in, gain_in}),
    .dout({addr_s, gain_s})
  );

  logic stb_s, ld_s, clr_n_s, cnt_s, trg_s, mux_s, tc_s;
  logic [2:0] oe_n_s;
  assign {stb_s, ld_s, clr_n_s, cnt_s, trg_s, mux_s, tc_s, oe_n_s} =
    pins_s[12:3];

  // Edge detection on synchronised strobe and trigger
  assign stb_fall = strobe_q_r & ~stb_s;
  assign trg_rise = ~trig_q_r & trg_s;

  // Address and gain registers
  logic [3:0] addr_r, addr_nxt;
  logic [1:0] gain_r, gain_nxt;
  logic start_settle;
  always_comb begin
    addr_nxt = addr_r;
    gain_nxt = gain_r;
    start_settle = 1'b0;
    if (stb_fall) begin
      if (!clr_n_s) begin
        addr_nxt = DCS_ADDR_RST;
      end else if (!ld_s) begin
        addr_nxt = addr_s & TOP_CH;
      end else if (cnt_s) begin
        // Wrap at the top channel of the variant
        addr_nxt = (addr_r >= TOP_CH) ? 4'h0 : addr_r + 4'h1;
      end
      gain_nxt = gain_s;
      start_settle = 1'b1;
    end
  end

  // Converter control: settle, then convert while serial shift runs
  dcs_state_t st_r, st_nxt;
  logic [DW-1:0] dly_r, dly_nxt;
  logic [BW-1:0] div_r, div_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [11:0] sh_r, sh_nxt;
  logic [11:0] res_r, res_nxt;
  logic sclk_r, sclk_nxt;
  always_comb begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    res_nxt = res_r;
    sclk_nxt = sclk_r;
    if (trg_rise) begin
      // Trigger aborts anything in flight and converts now
      st_nxt = DCS_CONV;
      div_nxt = '0;
      bit_nxt = '0;
      sh_nxt = adc_code;
      sclk_nxt = 1'b0;
    end else begin
      unique case (st_r)
        DCS_IDLE: begin
          if (start_settle) begin
            st_nxt = DCS_SETTLE;
            dly_nxt = DW'(DELAY_CYC - 1);
          end
        end
        DCS_SETTLE: begin
          if (dly_r != '0) begin
            dly_nxt = dly_r - DW'(1);
          end else if (trg_s) begin
            // Falling pulse edge converts only with trigger high
            st_nxt = DCS_CONV;
            div_nxt = '0;
            bit_nxt = '0;
            sh_nxt = adc_code;
            sclk_nxt = 1'b0;
          end else begin
            st_nxt = DCS_IDLE;
          end
        end
        DCS_CONV: begin
          // Data changes as the clock falls, stable while clock high
          if (div_r == BW'(BIT_DIV - 1)) begin
            div_nxt = '0;
            sclk_nxt = 1'b0;
            if (bit_r == 4'(DCS_RES_BITS - 1)) begin
              st_nxt = DCS_IDLE;
              res_nxt = adc_code;
            end else begin
              bit_nxt = bit_r + 4'h1;
              sh_nxt = {sh_r[10:0], 1'b0};
            end
          end else begin
            div_nxt = div_r + BW'(1);
            if (div_r == BW'(BIT_DIV / 2)) begin
              sclk_nxt = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Register all state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // Strobe copy matches the synchroniser's reset level, so no false fall; a trigger held high through reset gives a false rise after release
      strobe_q_r <= 1'b0;
      trig_q_r <= 1'b1;
      addr_r <= DCS_ADDR_RST;
      gain_r <= DCS_GAIN_RST;
      st_r <= DCS_IDLE;
      dly_r <= '0;
      div_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      res_r <= '0;
      sclk_r <= 1'b0;
    end else begin
      strobe_q_r <= stb_s;
      trig_q_r <= trg_s;
      addr_r <= addr_nxt;
      gain_r <= gain_nxt;
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      res_r <= res_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  // Outputs
  assign addr_out = addr_r;
  assign gain_out = gain_r;
  assign delay_out = (st_r == DCS_SETTLE);
  assign eoc = (st_r == DCS_CONV);
  assign ser_out = sh_r[11];
  assign ser_clk = sclk_r;
  assign data_o = {res_r[11] ^ tc_s, res_r[10:0]};

  // Per-channel switch, opened entirely when mux disabled
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_ch
      assign chan_sel[gi] = mux_s && (addr_r == 4'(gi));
    end
    for (gi = 0; gi < 3; gi++) begin : g_oe
      // Group 0 holds the MSB nibble
      assign data_oe[11-4*gi -: 4] = {4{~oe_n_s[gi]}};
    end
  endgenerate

  // Checks
  sequence s_fall;
    stb_fall && cnt_s && ld_s && clr_n_s;
  endsequence
  clear_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    stb_fall && !clr_n_s |=> addr_r == 4'h0)
    else $error("address not cleared");
  seq_inc_a: assert property (@(posedge mclk) disable iff (!rstn)
    s_fall |=> addr_r == (($past(addr_r) >= TOP_CH) ? 4'h0 :
                          $past(addr_r) + 4'h1))
    else $error("address did not step");
  hold_cnt_a: assert property (@(posedge mclk) disable iff (!rstn)
    stb_fall && ld_s && clr_n_s && !cnt_s |=> $stable(addr_r))
    else $error("address moved while count disabled");
  rand_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    stb_fall && !ld_s && clr_n_s |=> addr_r == ($past(addr_s) & TOP_CH))
    else $error("random address not loaded");
  mux_off_a: assert property (@(posedge mclk) disable iff (!rstn)
    !mux_s |-> chan_sel == 16'h0000)
    else $error("channel on while mux disabled");
  eoc_conv_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(eoc) |-> eoc [*8])
    else $error("conversion status too short");
  trig_start_a: assert property (@(posedge mclk) disable iff (!rstn)
    trg_rise |=> eoc && bit_r == 4'h0)
    else $error("trigger did not start conversion");
  addr_out_a: assert property (@(posedge mclk) disable iff (!rstn)
    addr_out == addr_r && addr_r <= TOP_CH)
    else $error("address output out of range");
  msb_code_a: assert property (@(posedge mclk) disable iff (!rstn)
    data_o[11] == (res_r[11] ^ tc_s))
    else $error("msb coding wrong");
  oe_grp_a: assert property (@(posedge mclk) disable iff (!rstn)
    oe_n_s[0] |-> data_oe[11:8] == 4'h0)
    else $error("group driven while disabled");
endmodule : dcs_sequencer

// >>> src/dcs_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/100ps
module dcs_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // System clock
  input wire logic rstn, // Sync reset, low
  input wire logic [W-1:0] din, // Asynchronous pins
  output logic [W-1:0] dout // Synchronised pins
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  // Next values: first stage feeds only the second
  always_comb begin
    s1_nxt = din;
    s2_nxt = s1_r;
  end

  // Register both stages
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= s1_nxt;
      dout <= s2_nxt;
    end
  end
endmodule : dcs_sync
